// >>> hw/ldu_pkg.sv
package ldu_pkg;

    localparam int XLEN     = 64;
    localparam int PA_W     = 32;
    localparam int WB_AW    = 8;
    localparam int FLD_W    = 5;
    localparam int OFF_W    = 16;
    localparam int OPC_LO   = 26;
    localparam int BASE_LO  = 21;
    localparam int RT_LO    = 16;
    localparam int HALF_W   = 32;
    localparam int BYTE_W   = 8;
    localparam int NBYTES   = XLEN / BYTE_W;
    localparam int LANE_LO  = 3;

    // primary opcodes
    localparam logic [5:0] OP_LEFT  = 6'h1A;
    localparam logic [5:0] OP_RIGHT = 6'h1B;
    localparam logic [5:0] OP_COP1  = 6'h35;
    localparam logic [5:0] OP_COP2  = 6'h36;

    localparam logic [2:0] ACC_DWORD = 3'h7;
    localparam logic [2:0] OFF_ZERO  = 3'h0;
    localparam logic [3:0] DW_BYTES  = 4'h8;

    // register map, byte addresses
    localparam logic [WB_AW-1:0] ADDR_CTRL   = 8'h00;
    localparam logic [WB_AW-1:0] ADDR_STATUS = 8'h04;
    localparam logic [WB_AW-1:0] ADDR_VA_LO  = 8'h08;
    localparam logic [WB_AW-1:0] ADDR_VA_HI  = 8'h0C;

    // control fields
    localparam int CB_MODE64 = 0;
    localparam int CB_KERNEL = 1;
    localparam int CB_MEM_BE = 2;
    localparam int CB_CPU_BE = 3;
    localparam int CB_SWAP   = 4;
    localparam int CB_CU1    = 5;
    localparam int CB_CU2    = 6;
    localparam int CTRL_W    = 7;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h03;

    // status fields
    localparam int SB_BUSY   = 0;
    localparam int SB_EXC_LO = 4;
    localparam int SB_NB_LO  = 8;
    localparam int SB_CNT_LO = 16;
    localparam int CNT_W     = 16;

    typedef enum logic [2:0] {
        EXC_NONE, EXC_TLB_MISS, EXC_TLB_INVALID, EXC_BUS_ERROR,
        EXC_ADDR_ERROR, EXC_COP_UNUSABLE, EXC_RESERVED
    } exc_e;

    typedef enum logic [1:0] {OPK_LEFT, OPK_RIGHT, OPK_COP1, OPK_COP2} opk_e;

    typedef struct packed {
        logic            valid;
        logic [31:0]     instr;
        logic [XLEN-1:0] base_val;
        logic [XLEN-1:0] tgt_val;
    } issue_s;

    typedef struct packed {
        logic             valid;
        logic [FLD_W-1:0] idx;
        logic [XLEN-1:0]  data;
    } reg_wr_s;

    typedef struct packed {
        logic            valid;
        logic [XLEN-1:0] virtual_addr;
    } tlb_req_s;

    typedef struct packed {
        logic            valid;
        logic [PA_W-1:0] paddr;
        logic            miss;
        logic            invalid;
    } tlb_rsp_s;

    typedef struct packed {
        logic            valid;
        logic [PA_W-1:0] addr;
        logic [2:0]      size;
    } mem_req_s;

    typedef struct packed {
        logic            valid;
        logic [XLEN-1:0] data;
        logic            bus_err;
    } mem_rsp_s;

    typedef struct packed {
        logic valid;
        exc_e code;
    } exc_s;

    function automatic logic [XLEN-1:0] byte_mask(input logic [3:0] n);
        logic [XLEN-1:0] m;
        m = '0;
        for (int i = 0; i < NBYTES; i++) begin
            if (i < int'(n)) begin
                m[i*BYTE_W +: BYTE_W] = 8'hFF;
            end
        end
        return m;
    endfunction

endpackage

// >>> hw/ldu_addr_gen.sv
`timescale 1ns/1ps
`default_nettype none
module ldu_addr_gen import ldu_pkg::*; (
    // effective address
    input  wire logic [XLEN-1:0]  base_val,
    input  wire logic [OFF_W-1:0] offset,
    input  wire logic             mode64,
    output logic      [XLEN-1:0]  virtual_addr,
    // access shaping
    input  wire opk_e             kind,
    input  wire logic [2:0]       va_lo,
    input  wire logic [2:0]       paddr_lo,
    input  wire logic             cpu_be,
    input  wire logic             mem_be,
    input  wire logic             swap,
    output logic      [2:0]       byte_idx,
    output logic      [2:0]       acc_size,
    output logic      [2:0]       mem_off
);
    logic [XLEN-1:0]   sum64;
    logic [HALF_W-1:0] sum32;

    always_comb begin
        sum64 = base_val + {{(XLEN-OFF_W){offset[OFF_W-1]}}, offset};
        sum32 = base_val[HALF_W-1:0]
              + {{(HALF_W-OFF_W){offset[OFF_W-1]}}, offset};
        virtual_addr = mode64 ? sum64 : {{HALF_W{sum32[HALF_W-1]}}, sum32};
    end

    always_comb begin
        byte_idx = va_lo ^ {3{cpu_be}};
        case (kind)
            OPK_LEFT: begin
                acc_size = byte_idx;
                mem_off  = mem_be ? ACC_DWORD - byte_idx : OFF_ZERO;
            end
            OPK_RIGHT: begin
                acc_size = ACC_DWORD - byte_idx;
                mem_off  = mem_be ? OFF_ZERO : byte_idx;
            end
            default: begin
                acc_size = ACC_DWORD;
                mem_off  = paddr_lo ^ {3{swap}};
            end
        endcase
    end
endmodule
`default_nettype wire

// >>> hw/ldu_merge.sv
`timescale 1ns/1ps
`default_nettype none
module ldu_merge import ldu_pkg::*; (
    // operation
    input  wire opk_e            kind,
    input  wire logic [2:0]      byte_idx,
    // data
    input  wire logic [XLEN-1:0] mem_data,
    input  wire logic [XLEN-1:0] old_val,
    output logic      [XLEN-1:0] result,
    output logic      [3:0]      nbytes
);
    logic [3:0] idx4;

    always_comb begin
        idx4   = {1'b0, byte_idx};
        result = mem_data;
        nbytes = DW_BYTES;
        case (kind)
            OPK_LEFT: begin
                nbytes = idx4 + 4'h1;
                result = (mem_data << (BYTE_W * int'(DW_BYTES - nbytes)))
                       | (old_val & byte_mask(DW_BYTES - nbytes));
            end
            OPK_RIGHT: begin
                nbytes = DW_BYTES - idx4;
                result = (mem_data >> (BYTE_W * int'(idx4)))
                       | (old_val & ~byte_mask(nbytes));
            end
            default: begin
                result = mem_data;
                nbytes = DW_BYTES;
            end
        endcase
    end
endmodule
`default_nettype wire

// >>> hw/doubleword_load_unit.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - coprocessor load fetches a doubleword and hands it to the target register
// - coprocessor load raises translation, bus, address and unusable faults
// - left partial load decodes as opcode 011010 with base, target, offset
// - right partial load decodes as opcode 011011 with the same fields
// - address is sign-extended 16-bit offset plus base, any byte allowed
// - left load puts addressed byte at top, fills down, keeps rest
// - right load puts addressed byte at bottom, fills up, keeps rest
// - each partial load moves between one and eight bytes
// - a pending target value is bypassed into the partial load
// - partial loads never fault for misalignment
// - partial loads need 64-bit or kernel mode, else reserved instruction
// - in 32-bit kernel mode the upper operand half is ignored
// - left load ignores the swap flag; little-endian memory forces zero offset
// - right load ignores the swap flag; big-endian memory clears offset
// - byte index is address low bits xor processor endian flag
// - right load size is doubleword minus index, upper bytes retained
// - left load size equals index; offset zero or seven minus index
// - offset appears on the low three physical address bits
// - right load size seven minus index; offset index or zero
module doubleword_load_unit import ldu_pkg::*; (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             nrst,
    // register bus
    input  wire logic             wb_cyc,
    input  wire logic             wb_stb,
    input  wire logic             wb_we,
    input  wire logic [WB_AW-1:0] wb_adr,
    input  wire logic [3:0]       wb_sel,
    input  wire logic [31:0]      wb_dat_w,
    output logic      [31:0]      wb_dat_r,
    output logic                  wb_ack,
    // instruction issue
    input  wire issue_s           issue,
    output logic                  issue_ready,
    input  wire reg_wr_s          fwd,
    // translation
    output tlb_req_s              tlb_req,
    input  wire tlb_rsp_s         tlb_rsp,
    // memory
    output mem_req_s              mem_req,
    input  wire mem_rsp_s         mem_rsp,
    // results
    output reg_wr_s               gpr_wr,
    output reg_wr_s               cop_wr,
    output exc_s                  exc
);
    typedef enum logic [1:0] {ST_IDLE, ST_XLATE, ST_MEM} state_e;

    state_e            state_reg;
    opk_e              kind_reg;
    logic [FLD_W-1:0]  rt_reg;
    logic [XLEN-1:0]   virtual_addr_reg;
    logic [XLEN-1:0]   tgt_reg;
    logic [PA_W-1:0]   paddr_reg;
    logic [CTRL_W-1:0] ctrl_reg;
    exc_e              last_exc_reg;
    logic [3:0]        nb_reg;
    logic [CNT_W-1:0]  cnt_reg;
    logic              ack_reg;
    logic [31:0]       dat_r_reg;
    reg_wr_s           gpr_reg;
    reg_wr_s           cop_reg;
    exc_s              exc_reg;

    logic [5:0]        opc;
    logic [FLD_W-1:0]  rt_in;
    logic [FLD_W-1:0]  base_idx;
    logic [XLEN-1:0]   base_in;
    logic [XLEN-1:0]   tgt_in;
    logic [XLEN-1:0]   virtual_addr_in;
    logic              dec_ok;
    opk_e              dec_kind;
    logic              taken;
    logic              partial_in;
    exc_e              pre_code;
    logic              fault_now;
    exc_e              fault_code;
    logic              done_now;
    logic [2:0]        byte_idx;
    logic [2:0]        acc_size;
    logic [2:0]        mem_off;
    logic [XLEN-1:0]   merged;
    logic [3:0]        nbytes;
    logic [31:0]       rd_mux;
    logic              mode64;
    logic              kernel;

    assign mode64 = ctrl_reg[CB_MODE64];
    assign kernel = ctrl_reg[CB_KERNEL];

    // decode of the issued word
    always_comb begin
        opc      = issue.instr[OPC_LO +: 6];
        rt_in    = issue.instr[RT_LO +: FLD_W];
        base_idx = issue.instr[BASE_LO +: FLD_W];
        dec_ok   = 1'b1;
        dec_kind = OPK_COP1;
        case (opc)
            OP_LEFT:  dec_kind = OPK_LEFT;
            OP_RIGHT: dec_kind = OPK_RIGHT;
            OP_COP1:  dec_kind = OPK_COP1;
            OP_COP2:  dec_kind = OPK_COP2;
            default:  dec_ok = 1'b0;
        endcase
    end

    // bypass of a same-cycle register write
    always_comb begin
        tgt_in  = issue.tgt_val;
        base_in = issue.base_val;
        if (fwd.valid && fwd.idx == rt_in) begin
            tgt_in = fwd.data;
        end
        if (fwd.valid && fwd.idx == base_idx) begin
            base_in = fwd.data;
        end
    end

    ldu_addr_gen u_addr (
        .base_val (base_in),
        .offset   (issue.instr[OFF_W-1:0]),
        .mode64   (mode64),
        .virtual_addr    (virtual_addr_in),
        .kind     (kind_reg),
        .va_lo    (virtual_addr_reg[2:0]),
        .paddr_lo (paddr_reg[2:0]),
        .cpu_be   (ctrl_reg[CB_CPU_BE]),
        .mem_be   (ctrl_reg[CB_MEM_BE]),
        .swap     (ctrl_reg[CB_SWAP]),
        .byte_idx (byte_idx),
        .acc_size (acc_size),
        .mem_off  (mem_off)
    );

    ldu_merge u_merge (
        .kind     (kind_reg),
        .byte_idx (byte_idx),
        .mem_data (mem_rsp.data),
        .old_val  (tgt_reg),
        .result   (merged),
        .nbytes   (nbytes)
    );

    // checks made before any memory traffic; mode fault ranks first
    always_comb begin
        partial_in = dec_kind == OPK_LEFT || dec_kind == OPK_RIGHT;
        pre_code   = EXC_NONE;
        if (partial_in && !mode64 && !kernel) begin
            pre_code = EXC_RESERVED;
        end else if ((dec_kind == OPK_COP1 && !ctrl_reg[CB_CU1])
                  || (dec_kind == OPK_COP2 && !ctrl_reg[CB_CU2])) begin
            pre_code = EXC_COP_UNUSABLE;
        // only the coprocessor load checks alignment
        end else if (!partial_in && virtual_addr_in[2:0] != OFF_ZERO) begin
            pre_code = EXC_ADDR_ERROR;
        end
    end

    assign taken = issue.valid && state_reg == ST_IDLE && dec_ok;

    always_comb begin
        fault_now  = 1'b0;
        fault_code = EXC_NONE;
        done_now   = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                fault_now  = taken && pre_code != EXC_NONE;
                fault_code = pre_code;
            end
            ST_XLATE: begin
                fault_now  = tlb_rsp.valid && (tlb_rsp.miss || tlb_rsp.invalid);
                fault_code = tlb_rsp.miss ? EXC_TLB_MISS : EXC_TLB_INVALID;
            end
            ST_MEM: begin
                fault_now  = mem_rsp.valid && mem_rsp.bus_err;
                fault_code = EXC_BUS_ERROR;
                done_now   = mem_rsp.valid && !mem_rsp.bus_err;
            end
            default: begin
                fault_now  = 1'b0;
                fault_code = EXC_NONE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (taken && pre_code == EXC_NONE) begin
                        state_reg <= ST_XLATE;
                    end
                end
                ST_XLATE: begin
                    if (tlb_rsp.valid) begin
                        state_reg <= fault_now ? ST_IDLE : ST_MEM;
                    end
                end
                ST_MEM: begin
                    if (mem_rsp.valid) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // operand capture; the target keeps tracking late writes while busy
    always_ff @(posedge clock) begin
        if (!nrst) begin
            kind_reg  <= OPK_LEFT;
            rt_reg    <= '0;
            virtual_addr_reg <= '0;
            tgt_reg   <= '0;
            paddr_reg <= '0;
        end else begin
            if (taken) begin
                kind_reg  <= dec_kind;
                rt_reg    <= rt_in;
                virtual_addr_reg <= virtual_addr_in;
                tgt_reg   <= tgt_in;
            end else if (fwd.valid && fwd.idx == rt_reg) begin
                tgt_reg <= fwd.data;
            end
            if (state_reg == ST_XLATE && tlb_rsp.valid) begin
                paddr_reg <= tlb_rsp.paddr;
            end
        end
    end

    // result and fault pulses
    always_ff @(posedge clock) begin
        if (!nrst) begin
            gpr_reg <= '0;
            cop_reg <= '0;
            exc_reg <= '0;
        end else begin
            // writes only on a clean finish
            gpr_reg.valid <= done_now
                          && (kind_reg == OPK_LEFT || kind_reg == OPK_RIGHT);
            gpr_reg.idx   <= rt_reg;
            gpr_reg.data  <= merged;
            cop_reg.valid <= done_now
                          && (kind_reg == OPK_COP1 || kind_reg == OPK_COP2);
            cop_reg.idx   <= rt_reg;
            cop_reg.data  <= mem_rsp.data;
            exc_reg.valid <= fault_now;
            exc_reg.code  <= fault_code;
        end
    end

    // status bookkeeping
    always_ff @(posedge clock) begin
        if (!nrst) begin
            last_exc_reg <= EXC_NONE;
            nb_reg       <= '0;
            cnt_reg      <= '0;
        end else begin
            if (fault_now) begin
                last_exc_reg <= fault_code;
            end
            if (done_now) begin
                nb_reg  <= nbytes;
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    always_comb begin
        rd_mux = '0;
        case (wb_adr)
            ADDR_CTRL:   rd_mux[CTRL_W-1:0] = ctrl_reg;
            ADDR_STATUS: begin
                rd_mux[SB_BUSY]             = state_reg != ST_IDLE;
                rd_mux[SB_EXC_LO +: 3]      = last_exc_reg;
                rd_mux[SB_NB_LO +: 4]       = nb_reg;
                rd_mux[SB_CNT_LO +: CNT_W]  = cnt_reg;
            end
            ADDR_VA_LO:  rd_mux = virtual_addr_reg[HALF_W-1:0];
            ADDR_VA_HI:  rd_mux = virtual_addr_reg[XLEN-1:HALF_W];
            default:     rd_mux = '0;
        endcase
    end

    // one wait state; a write lands on the edge the master sees ack
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ack_reg   <= 1'b0;
            dat_r_reg <= '0;
            ctrl_reg  <= CTRL_RST;
        end else begin
            ack_reg   <= wb_cyc && wb_stb && !ack_reg;
            dat_r_reg <= rd_mux;
            if (wb_cyc && wb_stb && wb_we && ack_reg
                && wb_adr == ADDR_CTRL && wb_sel[0]) begin
                ctrl_reg <= wb_dat_w[CTRL_W-1:0];
            end
        end
    end

    assign wb_ack      = ack_reg;
    assign wb_dat_r    = dat_r_reg;
    assign issue_ready = state_reg == ST_IDLE;
    assign gpr_wr      = gpr_reg;
    assign cop_wr      = cop_reg;
    assign exc         = exc_reg;

    always_comb begin
        tlb_req.valid = state_reg == ST_XLATE;
        tlb_req.virtual_addr = virtual_addr_reg;
        mem_req.valid = state_reg == ST_MEM;
        // offset on the low physical bits
        mem_req.addr  = {paddr_reg[PA_W-1:LANE_LO], mem_off};
        mem_req.size  = acc_size;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence xlate_ok;
        tlb_req.valid && tlb_rsp.valid && !tlb_rsp.miss && !tlb_rsp.invalid;
    endsequence

    sequence cop_finish;
        mem_req.valid && mem_rsp.valid && !mem_rsp.bus_err
        && (kind_reg == OPK_COP1 || kind_reg == OPK_COP2);
    endsequence

    left_decode_a: assert property (
        taken && opc == OP_LEFT && (mode64 || kernel)
        |=> tlb_req.valid && kind_reg == OPK_LEFT)
        else $error("left load not started");

    right_decode_a: assert property (
        taken && opc == OP_RIGHT && (mode64 || kernel)
        |=> tlb_req.valid && kind_reg == OPK_RIGHT)
        else $error("right load not started");

    reserved_mode_a: assert property (
        taken && partial_in && !mode64 && !kernel
        |=> exc.valid && exc.code == EXC_RESERVED && !tlb_req.valid)
        else $error("reserved fault missing");

    cop_unusable_a: assert property (
        taken && opc == OP_COP1 && !ctrl_reg[CB_CU1]
        |=> exc.valid && exc.code == EXC_COP_UNUSABLE)
        else $error("unusable fault missing");

    fault_no_write_a: assert property (
        exc.valid |-> !gpr_wr.valid && !cop_wr.valid)
        else $error("write during fault");

    left_size_a: assert property (
        mem_req.valid && kind_reg == OPK_LEFT
        |-> mem_req.size == byte_idx
         && mem_req.addr[2:0] == (ctrl_reg[CB_MEM_BE]
                                  ? ACC_DWORD - byte_idx : OFF_ZERO))
        else $error("left size or offset wrong");

    right_size_a: assert property (
        mem_req.valid && kind_reg == OPK_RIGHT
        |-> mem_req.size == ACC_DWORD - byte_idx
         && mem_req.addr[2:0] == (ctrl_reg[CB_MEM_BE]
                                  ? OFF_ZERO : byte_idx))
        else $error("right size or offset wrong");

    va32_a: assert property (
        tlb_req.valid && !mode64
        |-> tlb_req.virtual_addr[XLEN-1:HALF_W] == {HALF_W{tlb_req.virtual_addr[HALF_W-1]}})
        else $error("upper address half not ignored");

    mem_follows_a: assert property (
        xlate_ok |=> mem_req.valid
                     && (mem_req.size == ACC_DWORD
                         || kind_reg == OPK_LEFT || kind_reg == OPK_RIGHT))
        else $error("memory access not issued");

    cop_data_a: assert property (
        cop_finish |=> cop_wr.valid && cop_wr.data == $past(mem_rsp.data)
                       && cop_wr.idx == rt_reg)
        else $error("coprocessor data lost");

    byte_count_a: assert property (
        mem_req.valid && (kind_reg == OPK_LEFT || kind_reg == OPK_RIGHT)
        |-> nbytes == {1'b0, mem_req.size} + 4'h1)
        else $error("byte count out of range");

endmodule
`default_nettype wire

// >>> verification/mem_partner.sv
`timescale 1ns/1ps
`default_nettype none
// stands in for translation and memory; answers after a settable stall
module mem_partner import ldu_pkg::*; (
    // clock and reset
    input  wire logic            clock,
    input  wire logic            nrst,
    // block side
    input  wire tlb_req_s        tlb_req,
    output tlb_rsp_s             tlb_rsp,
    input  wire mem_req_s        mem_req,
    output mem_rsp_s             mem_rsp,
    // scenario controls: stall, faults {bus, invalid, miss}, data
    input  wire logic [2:0]      slow,
    input  wire logic [2:0]      flt,
    input  wire logic [XLEN-1:0] rdata
);
    logic [2:0] wait_reg;
    // released lines toggle so stale values never pass for answers
    always_ff @(posedge clock) begin
        tlb_rsp <= '{1'b0, ~tlb_rsp.paddr, 1'b0, 1'b0};
        mem_rsp <= '{1'b0, ~mem_rsp.data, 1'b0};
        if (!nrst) begin
            wait_reg <= 3'h0;
            tlb_rsp <= '0;
            mem_rsp <= '0;
        end else if (tlb_req.valid && !tlb_rsp.valid) begin
            wait_reg <= wait_reg + 3'h1;
            if (wait_reg == slow) begin
                tlb_rsp <= '{1'b1, tlb_req.virtual_addr[PA_W-1:0], flt[0], flt[1]};
                wait_reg <= 3'h0;
            end
        end else if (mem_req.valid && !mem_rsp.valid) begin
            wait_reg <= wait_reg + 3'h1;
            if (wait_reg == slow) begin
                mem_rsp <= '{1'b1, rdata, flt[2]};
                wait_reg <= 3'h0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import ldu_pkg::*;;
    logic        clock = 0, nrst = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0;
    logic [7:0]  wb_adr = 0;
    logic [3:0]  wb_sel = 4'hF;
    logic [31:0] wb_dat_w = 0, wb_dat_r, seed = 32'h2F34, q;
    logic        wb_ack, issue_ready;
    logic [2:0]  slow = 0, flt = 0;
    logic [63:0] rdata = 0;
    logic [6:0]  c;
    issue_s      issue = '0;
    reg_wr_s     fwd = '0, gpr_wr, cop_wr;
    tlb_req_s    tlb_req;
    tlb_rsp_s    tlb_rsp;
    mem_req_s    mem_req;
    mem_rsp_s    mem_rsp;
    exc_s        exc;
    int          errors = 0, cmp_count = 0;
    doubleword_load_unit i_dut (.clock, .nrst, .wb_cyc, .wb_stb, .wb_we,
        .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .issue,
        .issue_ready, .fwd, .tlb_req, .tlb_rsp, .mem_req, .mem_rsp,
        .gpr_wr, .cop_wr, .exc);
    mem_partner i_mem (.clock, .nrst, .tlb_req, .tlb_rsp, .mem_req,
        .mem_rsp, .slow, .flt, .rdata);
    always #2 clock = ~clock;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            errors++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} <= {2'b11, we, a, d};
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        q = wb_dat_r;
        {wb_cyc, wb_stb} <= 2'b00;
        chk(wb_ack, "no bus ack");
        @(posedge clock);
    endtask
    // one load with random operands; va[2:0] is forced to lo
    task automatic run(input logic [5:0] op, input logic [2:0] lo);
        logic [63:0] b, old, nv, md, va, ex;
        logic [15:0] o;
        logic [2:0]  ix, sz, of, f;
        logic        part;
        exc_e        ee;
        int          n;
        b = {rnd(), rnd()};
        old = {rnd(), rnd()};
        nv = {rnd(), rnd()};
        md = {rnd(), rnd()};
        q = rnd();
        o = q[15:0];
        b[2:0] = lo - o[2:0];
        q = rnd();
        f = q[2:0] & {3{q[4:3] == 2'b00}};
        {rdata, flt, slow} <= {md, f, q[10:8]};
        va = b + {{48{o[15]}}, o};
        if (!c[CB_MODE64]) va = {{32{va[31]}}, va[31:0]};
        ix = va[2:0] ^ {3{c[CB_CPU_BE]}};
        part = (op == OP_LEFT) || (op == OP_RIGHT);
        ee = EXC_NONE;
        if (part && !c[CB_MODE64] && !c[CB_KERNEL]) ee = EXC_RESERVED;
        else if (!part && !c[op == OP_COP1 ? CB_CU1 : CB_CU2])
            ee = EXC_COP_UNUSABLE;
        else if (!part && va[2:0] != 3'h0) ee = EXC_ADDR_ERROR;
        else if (f[0]) ee = EXC_TLB_MISS;
        else if (f[1]) ee = EXC_TLB_INVALID;
        else if (f[2]) ee = EXC_BUS_ERROR;
        sz = op == OP_LEFT ? ix : (op == OP_RIGHT ? 3'h7 - ix : ACC_DWORD);
        of = op == OP_LEFT ? (c[CB_MEM_BE] ? 3'h7 - ix : 3'h0)
           : op == OP_RIGHT ? (c[CB_MEM_BE] ? 3'h0 : ix) : {3{c[CB_SWAP]}};
        ex = op == OP_LEFT ? (md << 8*(7-ix)) | (nv & ((64'h1 << 8*(7-ix)) - 1))
           : op == OP_RIGHT ? (md >> 8*ix) | (nv & ~((64'h1 << 8*(8-ix)) - 1))
           : md;
        issue <= '{1'b1, {op, 5'd1, 5'd2, o}, b, old};
        // odd offsets bypass in the issue cycle, even ones while in flight
        fwd <= '{lo[0], 5'd2, nv};
        n = 0;
        do begin
            @(posedge clock);
            n++;
            if (n == 1) chk(issue_ready, "not ready");
            if (n == 1) issue.valid <= 1'b0;
            if (n == 1) fwd.valid <= !lo[0];
            if (n == 2) fwd.valid <= 1'b0;
            if (tlb_req.valid === 1'b1)
                chk(tlb_req.virtual_addr === va, "virtual_addr");
            if (mem_req.valid === 1'b1) begin
                chk(mem_req.addr === {va[31:3], of}, "off");
                chk(mem_req.addr[2:0] === of, "low bits");
                chk(mem_req.size === sz, "size");
            end
        end while (gpr_wr.valid !== 1'b1 && cop_wr.valid !== 1'b1
                   && exc.valid !== 1'b1 && n < 60);
        chk(exc.valid === (ee != EXC_NONE) && (ee == EXC_NONE || exc.code === ee),
            "fault code");
        chk(gpr_wr.valid === (part && ee == EXC_NONE)
            && cop_wr.valid === (!part && ee == EXC_NONE), "commit");
        if (gpr_wr.valid === 1'b1) begin
            chk(gpr_wr.idx === 5'd2, "merge index");
            chk(gpr_wr.data === ex, "merge");
        end
        if (cop_wr.valid === 1'b1)
            chk(cop_wr.idx === 5'd2 && cop_wr.data === ex, "cop");
    endtask
    task automatic setc(input logic [6:0] v);
        c = v;
        wb(1'b1, ADDR_CTRL, {25'h0, v});
    endtask
    task give_verdict;
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clock);
        errors++;
        give_verdict;
    end
    initial begin
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        wb(1'b0, ADDR_CTRL, 32'h0);
        chk(q === 32'h3, "ctrl reset value");
        wb(1'b1, 8'h10, 32'hFFFF_FFFF);
        wb(1'b0, 8'h10, 32'h0);
        chk(q === 32'h0, "unmapped read");
        wb(1'b0, ADDR_CTRL, 32'h0);
        chk(q === 32'h3, "ctrl hit by unmapped write");
        // the last sixteen leave the mode random to reach 32-bit user
        for (int i = 0; i < 96; i++) begin
            q = rnd();
            if (i < 80) q[i % 2] = 1'b1;
            setc(q[6:0]);
            run(i[3] ? OP_LEFT : OP_RIGHT, i[2:0]);
        end
        for (int i = 0; i < 24; i++) begin
            q = rnd();
            setc(q[6:0] | 7'h01);
            run(i[0] ? OP_COP1 : OP_COP2, i[3] ? i[2:0] : 3'h0);
        end
        give_verdict;
    end
endmodule
`default_nettype wire
